// ===== inc/atx_fmt_pkg.sv
package atx_fmt_pkg;
   // Transaction codes, bits [7:4] of the control quadlet
   localparam logic [3:0] TCODE_WR_QUAD = 4'h0;
   localparam logic [3:0] TCODE_WR_BLOCK = 4'h1;
   localparam logic [3:0] TCODE_WR_RESP = 4'h2;
   localparam logic [3:0] TCODE_RD_QUAD = 4'h4;
   localparam logic [3:0] TCODE_RD_BLOCK = 4'h5;
   localparam logic [3:0] TCODE_RD_QRESP = 4'h6;
   localparam logic [3:0] TCODE_RD_BRESP = 4'h7;
   localparam logic [3:0] TCODE_LOCK_REQ = 4'h9;
   localparam logic [3:0] TCODE_STREAM = 4'hA;
   localparam logic [3:0] TCODE_LOCK_RESP = 4'hB;
   localparam logic [3:0] TCODE_UNFORMATTED = 4'hE;
   // Control quadlet field positions
   localparam int CTRL_TCODE_LSB = 4;
   localparam int CTRL_LOW_W = 16;
   localparam int CTRL_SPD_LSB = 16;
   localparam int CTRL_UNF_COUNT_LSB = 24;
   localparam int CTRL_UNF_COUNT_W = 8;
   // Length and destination sit in the upper half of their quadlets
   localparam int LEN_LSB = 16;
   localparam int LEN_W = 16;
   localparam int DEST_LSB = 16;
   // Speed codes
   localparam logic [1:0] SPEED_100 = 2'b00;
   localparam logic [1:0] SPEED_200 = 2'b01;
   localparam logic [1:0] SPEED_400 = 2'b10;
   localparam logic [1:0] SPEED_UNDEF = 2'b11;
   // Host quadlets still to read after the source quadlet is built
   localparam int COUNT_W = 15;
   localparam logic [COUNT_W-1:0] REST_NODATA = 15'h0001;
   localparam logic [COUNT_W-1:0] REST_QUAD = 15'h0002;
   localparam logic [COUNT_W-1:0] REST_BLOCK = 15'h0002;
   // Reset values
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;
   localparam logic [15:0] HALF_RESET = 16'h0000;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 15'h0000;
endpackage : atx_fmt_pkg

// ===== rtl/async_transmit_packet_formatter.sv
// Contract
// - Partial last quadlet is completed with zero bytes; only whole quadlets sent.
// - Unformatted: control quadlet not sent, rest sent raw, no CRC.
// - Stream packet with zero length is sent as an empty stream packet.
// - Stream packets go out in the asynchronous phase, isochronous wire format.
// - Speed field: 00 100, 01 200, 10 400, 11 undefined.
`timescale 1ns/10ps
`default_nettype none
module async_transmit_packet_formatter
(
   input wire logic clock,
   input wire logic reset,
   input wire logic async_phase,
   input wire logic [15:0] node_id,
   input wire logic [31:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [31:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic tx_first,
   output logic tx_last,
   output logic [1:0] tx_speed,
   output logic tx_crc_enable,
   output logic tx_stream,
   output logic busy,
   output logic format_error
);
   typedef enum logic [1:0] {S_CTRL, S_DEST, S_SRC, S_BODY} state_e;
   function automatic logic [31:0] pad_mask(input logic [1:0] n);
      pad_mask = (n == 2'd0) ? 32'hFFFF_FFFF : ~(32'hFFFF_FFFF >> {n, 3'b000});
   endfunction : pad_mask
   function automatic logic [14:0] quads(input logic [15:0] len);
      quads = 15'(({1'b0, len} + 17'h0_0003) >> 2);
   endfunction : quads
   state_e state_reg, state_next;
   logic [15:0] ctrl_reg, ctrl_next, hold_reg, hold_next, len_field;
   logic [14:0] remain_reg, remain_next;
   logic [1:0] len_reg, len_next, pad_reg, pad_next, tx_speed_reg, tx_speed_next;
   logic len_pend_reg, len_pend_next, data_reg, data_next, skip_reg, skip_next;
   logic unf_reg, unf_next, first_pend_reg, first_pend_next;
   logic [31:0] tx_data_reg, tx_data_next, emit_data;
   logic tx_valid_reg, tx_valid_next, tx_first_reg, tx_first_next, tx_last_reg, tx_last_next;
   logic crc_reg, crc_next, stream_reg, stream_next, in_take, emit, emit_last;
   logic in_ready_reg, in_ready_next, busy_reg, busy_next, err_reg, err_next;
   logic [3:0] tcode;
   logic [7:0] unf_count;
   assign in_take = in_valid && in_ready_reg;
   assign tcode = in_data[atx_fmt_pkg::CTRL_TCODE_LSB +: 4];
   assign len_field = in_data[atx_fmt_pkg::LEN_LSB +: atx_fmt_pkg::LEN_W];
   assign unf_count = in_data[atx_fmt_pkg::CTRL_UNF_COUNT_LSB +: atx_fmt_pkg::CTRL_UNF_COUNT_W];

   always_comb
   begin
      state_next = state_reg;
      ctrl_next = ctrl_reg;
      hold_next = hold_reg;
      remain_next = remain_reg;
      len_next = len_reg;
      len_pend_next = len_pend_reg;
      data_next = data_reg;
      skip_next = skip_reg;
      unf_next = unf_reg;
      first_pend_next = first_pend_reg;
      tx_speed_next = tx_speed_reg;
      crc_next = crc_reg;
      stream_next = stream_reg;
      busy_next = busy_reg;
      err_next = 1'b0;
      emit = 1'b0;
      emit_last = 1'b0;
      emit_data = in_data;
      pad_next = 2'd0;
      tx_data_next = tx_data_reg;
      tx_valid_next = tx_valid_reg && !tx_ready;
      tx_first_next = tx_first_reg;
      tx_last_next = tx_last_reg;
      unique case (state_reg)
         S_CTRL:
            if (in_take)
            begin
               ctrl_next = in_data[atx_fmt_pkg::CTRL_LOW_W-1:0];
               first_pend_next = 1'b1;
               busy_next = 1'b1;
               data_next = 1'b0;
               skip_next = 1'b0;
               len_pend_next = 1'b0;
               unf_next = 1'b0;
               crc_next = 1'b1;
               stream_next = 1'b0;
               state_next = S_DEST;
               tx_speed_next = in_data[atx_fmt_pkg::CTRL_SPD_LSB +: 2];
               err_next = (tx_speed_next == atx_fmt_pkg::SPEED_UNDEF);
               if (err_next)
                  tx_speed_next = atx_fmt_pkg::SPEED_100;
               unique case (tcode)
                  atx_fmt_pkg::TCODE_RD_QUAD, atx_fmt_pkg::TCODE_WR_RESP:
                     remain_next = atx_fmt_pkg::REST_NODATA;
                  atx_fmt_pkg::TCODE_WR_QUAD, atx_fmt_pkg::TCODE_RD_QRESP,
                  atx_fmt_pkg::TCODE_RD_BLOCK:
                     remain_next = atx_fmt_pkg::REST_QUAD;
                  atx_fmt_pkg::TCODE_WR_BLOCK, atx_fmt_pkg::TCODE_RD_BRESP,
                  atx_fmt_pkg::TCODE_LOCK_REQ, atx_fmt_pkg::TCODE_LOCK_RESP:
                  begin
                     remain_next = atx_fmt_pkg::REST_BLOCK;
                     len_pend_next = 1'b1;
                  end
                  atx_fmt_pkg::TCODE_STREAM:
                     stream_next = 1'b1;
                  atx_fmt_pkg::TCODE_UNFORMATTED:
                  begin
                     unf_next = 1'b1;
                     crc_next = 1'b0;
                     remain_next = {7'h00, unf_count};
                     state_next = (unf_count == 8'h00) ? S_CTRL : S_BODY;
                     busy_next = (unf_count != 8'h00);
                  end
                  default:
                  begin
                     remain_next = atx_fmt_pkg::REST_NODATA;
                     err_next = 1'b1;
                  end
               endcase
            end
         S_DEST:
            if (in_take)
            begin
               hold_next = in_data[15:0];
               emit = 1'b1;
               if (stream_reg)
               begin
                  emit_last = (len_field == 16'h0000);
                  remain_next = 15'h0001 + quads(len_field);
                  len_next = len_field[1:0];
                  skip_next = 1'b1;
                  state_next = S_BODY;
               end
               else
               begin
                  emit_data = {in_data[atx_fmt_pkg::DEST_LSB +: 16], ctrl_reg};
                  state_next = S_SRC;
               end
            end
         S_SRC:
            if (!tx_valid_reg || tx_ready)
            begin
               emit = 1'b1;
               emit_data = {node_id, hold_reg};
               state_next = S_BODY;
            end
         S_BODY:
            if (in_take)
            begin
               remain_next = remain_reg - 15'h0001;
               if (skip_reg)
               begin
                  skip_next = 1'b0;
                  data_next = 1'b1;
               end
               else if (len_pend_reg && remain_reg == 15'h0001)
               begin
                  emit = 1'b1;
                  emit_last = (len_field == 16'h0000);
                  remain_next = quads(len_field);
                  len_next = len_field[1:0];
                  len_pend_next = 1'b0;
                  data_next = 1'b1;
               end
               else
               begin
                  emit = 1'b1;
                  emit_last = (remain_reg == 15'h0001);
                  pad_next = (data_reg && emit_last) ? len_reg : 2'd0;
                  emit_data = in_data & pad_mask(pad_next);
               end
               if (remain_next == atx_fmt_pkg::COUNT_RESET)
               begin
                  state_next = S_CTRL;
                  busy_next = 1'b0;
               end
            end
      endcase
      if (emit)
      begin
         tx_data_next = emit_data;
         tx_valid_next = 1'b1;
         tx_last_next = emit_last;
         tx_first_next = first_pend_reg;
      end
      // Input is taken only when the output slot is sure to be free
      in_ready_next = !in_take && !tx_valid_next && !emit &&
         ((state_next == S_CTRL && async_phase) || state_next == S_DEST ||
          state_next == S_BODY);
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state_reg <= S_CTRL;
         ctrl_reg <= atx_fmt_pkg::HALF_RESET;
         hold_reg <= atx_fmt_pkg::HALF_RESET;
         remain_reg <= atx_fmt_pkg::COUNT_RESET;
         len_reg <= 2'd0;
         pad_reg <= 2'd0;
         len_pend_reg <= 1'b0;
         data_reg <= 1'b0;
         skip_reg <= 1'b0;
         unf_reg <= 1'b0;
         first_pend_reg <= 1'b0;
         tx_data_reg <= atx_fmt_pkg::DATA_RESET;
         tx_valid_reg <= 1'b0;
         tx_first_reg <= 1'b0;
         tx_last_reg <= 1'b0;
         tx_speed_reg <= atx_fmt_pkg::SPEED_100;
         crc_reg <= 1'b1;
         stream_reg <= 1'b0;
         in_ready_reg <= 1'b0;
         busy_reg <= 1'b0;
         err_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         ctrl_reg <= ctrl_next;
         hold_reg <= hold_next;
         remain_reg <= remain_next;
         len_reg <= len_next;
         pad_reg <= emit ? pad_next : pad_reg;
         len_pend_reg <= len_pend_next;
         data_reg <= data_next;
         skip_reg <= skip_next;
         unf_reg <= unf_next;
         first_pend_reg <= emit ? 1'b0 : first_pend_next;
         tx_data_reg <= tx_data_next;
         tx_valid_reg <= tx_valid_next;
         tx_first_reg <= tx_first_next;
         tx_last_reg <= tx_last_next;
         tx_speed_reg <= tx_speed_next;
         crc_reg <= crc_next;
         stream_reg <= stream_next;
         in_ready_reg <= in_ready_next;
         busy_reg <= busy_next;
         err_reg <= err_next;
      end
   end

   assign in_ready = in_ready_reg;
   assign tx_data = tx_data_reg;
   assign tx_valid = tx_valid_reg;
   assign tx_first = tx_first_reg;
   assign tx_last = tx_last_reg;
   assign tx_speed = tx_speed_reg;
   assign tx_crc_enable = crc_reg;
   assign tx_stream = stream_reg;
   assign busy = busy_reg;
   assign format_error = err_reg;

   a_pad_zero: assert property (@(posedge clock) disable iff (reset)
      tx_valid_reg && pad_reg != 2'd0 |-> tx_last_reg && (tx_data_reg & ~pad_mask(pad_reg)) == 32'h0000_0000)
      else $error("Padding bytes of last quadlet not zero");
   a_unf_no_crc: assert property (@(posedge clock) disable iff (reset)
      tx_valid_reg && unf_reg |-> !tx_crc_enable && !tx_stream)
      else $error("Unformatted packet sent with CRC");
   a_unf_skip_ctrl: assert property (@(posedge clock) disable iff (reset)
      in_take && state_reg == S_CTRL && tcode == atx_fmt_pkg::TCODE_UNFORMATTED |=> !tx_first_reg || !tx_valid_reg || tx_data_reg != $past(in_data))
      else $error("Unformatted control quadlet was sent");
   a_empty_stream: assert property (@(posedge clock) disable iff (reset)
      in_take && state_reg == S_DEST && stream_reg && len_field == 16'h0000 |=> tx_valid_reg && tx_last_reg && tx_stream && tx_first_reg)
      else $error("Empty stream packet not sent as single quadlet");
   a_async_phase: assert property (@(posedge clock) disable iff (reset)
      in_take && state_reg == S_CTRL |-> $past(async_phase))
      else $error("Packet started outside asynchronous phase");
   a_speed_defined: assert property (@(posedge clock) disable iff (reset)
      tx_valid_reg |-> tx_speed_reg != atx_fmt_pkg::SPEED_UNDEF)
      else $error("Undefined speed code on output");
   a_block_count: assert property (@(posedge clock) disable iff (reset)
      in_take && state_reg == S_BODY && len_pend_reg && remain_reg == 15'h0001 |=> remain_reg == quads($past(len_field)))
      else $error("Block data quadlet count wrong");
   a_ctrl_leaves: assert property (@(posedge clock) disable iff (reset)
      in_take && state_reg == S_CTRL && tcode != atx_fmt_pkg::TCODE_UNFORMATTED |=> state_reg == S_DEST && busy_reg)
      else $error("Control quadlet not decoded");
endmodule : async_transmit_packet_formatter
`default_nettype wire

// ===== bench/atx_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module atx_host_model
(
   input wire logic clock,
   input wire logic reset,
   input wire logic stall,
   input wire logic in_ready,
   output logic [31:0] in_data,
   output logic in_valid
);
   logic [31:0] q[$];

   // Holds each quadlet until taken; a released bus inverts its value on every idle cycle
   always @(posedge clock or posedge reset)
      if (reset)
      begin
         in_valid <= 1'b0;
         in_data <= 32'h0000_0000;
      end
      else if (!in_valid || in_ready)
      begin
         if (in_valid)
            void'(q.pop_front());
         if (q.size() != 0 && !stall)
         begin
            in_valid <= 1'b1;
            in_data <= q[0];
         end
         else
         begin
            in_valid <= 1'b0;
            in_data <= ~in_data;
         end
      end

   // Builds one packet, queues it for the formatter and hands it back
   task automatic packet(input logic [3:0] tc, input logic [1:0] spd, input logic [15:0] len,
      input logic junk, input logic [31:0] r, output logic [31:0] pk[$]);
      logic rsp, blk;
      logic [31:0] d;
      int nq;
      rsp = tc inside {4'h2, 4'h6, 4'h7, 4'hB};
      blk = tc inside {4'h1, 4'h7, 4'h9, 4'hB};
      nq = (int'(len) + 3) / 4;
      pk = {};
      pk.push_back({(tc == 4'hE) ? len[7:0] : 8'h00, 6'h00, spd, r[15:10], 2'b01, tc, 3'h0,
         rsp & r[0]});
      if (tc == 4'hE)
         for (int i = 0; i < len; i++)
            pk.push_back((len == 2 && i == 1) ? ~pk[1] : r ^ 32'(i));
      else if (tc == 4'hA)
      begin
         pk.push_back({len, r[15:8], 4'hA, r[3:0]});
         pk.push_back(32'(nq));
      end
      else
      begin
         pk.push_back(r);
         pk.push_back(rsp ? {r[19:16], 28'h000_0000} : {r[31:2], 2'b00});
         if (tc == 4'h0 || tc == 4'h6)
            pk.push_back(~r);
         if (tc == 4'h5)
            pk.push_back({len, 16'h0000});
         if (blk)
            pk.push_back({len, (tc == 4'h9 || tc == 4'hB) ? r[15:0] : 16'h0000});
      end
      if (tc == 4'hA || blk)
         for (int i = 0; i < nq; i++)
         begin
            d = {8'(4 * i + 1), 8'(4 * i + 2), 8'(4 * i + 3), 8'(4 * i + 4)};
            if (!junk && len - 4 * i < 4)
               d = d & ~(32'hFFFF_FFFF >> (8 * (len - 4 * i)));
            pk.push_back(d);
         end
      foreach (pk[i])
         q.push_back(pk[i]);
   endtask : packet
endmodule : atx_host_model
`default_nettype wire

// ===== bench/async_transmit_packet_formatter_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module async_transmit_packet_formatter_tb_top;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic async_phase = 1'b0;
   logic [15:0] node_id = 16'h0000;
   logic tx_ready = 1'b0;
   logic stall = 1'b0;
   logic slow = 1'b0;
   logic hold_off = 1'b1;
   logic [31:0] in_data, tx_data;
   logic in_valid, in_ready, tx_valid, tx_first, tx_last, tx_crc_enable, tx_stream;
   logic busy, format_error;
   logic [1:0] tx_speed;
   logic [39:0] exp_q[$];
   logic [39:0] e;
   logic [3:0] tcs[12] = '{4'h4, 4'h2, 4'h0, 4'h6, 4'h5, 4'h1, 4'h7, 4'h9, 4'hA, 4'hB, 4'hE, 4'h3};
   int lens[8] = '{0, 1, 2, 3, 4, 5, 8, 13};
   int failures = 0, n_tests = 0, seed = 41775, beats = 0, n_err = 0, exp_err = 0;

   always #2.5 clock = ~clock;

   async_transmit_packet_formatter u_async_transmit_packet_formatter (.clock(clock),
      .reset(reset), .async_phase(async_phase), .node_id(node_id), .in_data(in_data),
      .in_valid(in_valid), .in_ready(in_ready), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_first(tx_first), .tx_last(tx_last), .tx_speed(tx_speed),
      .tx_crc_enable(tx_crc_enable), .tx_stream(tx_stream), .busy(busy),
      .format_error(format_error));
   atx_host_model u_atx_host_model (.clock(clock), .reset(reset), .stall(stall),
      .in_ready(in_ready), .in_data(in_data), .in_valid(in_valid));

   task automatic check(input logic [63:0] seen, input logic [63:0] expv);
      n_tests++;
      if (seen !== expv)
      begin
         failures++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask : check

   task automatic complete_run;
      $display("Mismatches %0d, comparisons %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   function automatic logic [31:0] pad(input logic [31:0] d, input int rem);
      return (rem >= 4) ? d : d & ~(32'hFFFF_FFFF >> (8 * rem));
   endfunction : pad

   // Bus quadlets with care, first, last, speed, crc and stream flags
   task automatic expect_pkt(input logic [3:0] tc, input logic [1:0] spd, input int len,
      input logic [31:0] pk[$]);
      logic [32:0] it[$];
      logic [4:0] at;
      logic blk;
      at = {(spd == 2'b11) ? 2'b00 : spd, tc != 4'hE, tc == 4'hA};
      blk = tc inside {4'h1, 4'h7, 4'h9, 4'hB};
      if (tc == 4'hE)
      begin
         for (int i = 1; i < pk.size(); i++)
            it.push_back({1'b1, pk[i]});
      end
      else if (tc == 4'hA)
      begin
         it.push_back({1'b1, pk[1]});
         for (int i = 3; i < pk.size(); i++)
            it.push_back({1'b1, pad(pk[i], len - 4 * (i - 3))});
      end
      else
      begin
         it.push_back({1'b1, pk[1][31:16], pk[0][15:0]});
         it.push_back({1'b1, node_id, pk[1][15:0]});
         for (int i = 2; i < pk.size(); i++)
            it.push_back({1'b1, (blk && i > 3) ? pad(pk[i], len - 4 * (i - 4)) : pk[i]});
      end
      foreach (it[i])
         exp_q.push_back({it[i][32], i == 0, i == it.size() - 1, at, it[i][31:0]});
   endtask : expect_pkt

   always @(posedge clock)
   begin
      tx_ready <= ({$random(seed)} % 4) >= (slow ? 3 : 1);
      stall <= slow && ({$random(seed)} % 2 == 1);
      async_phase <= !hold_off && ({$random(seed)} % 4 != 0);
   end

   always @(posedge clock)
      if (!reset && tx_valid && tx_ready)
      begin
         beats++;
         if (exp_q.size() == 0)
            check(1, 0);
         else
         begin
            e = exp_q.pop_front();
            check({tx_first, tx_last}, e[38:37]);
            if (e[39])
               check(tx_data, e[31:0]);
            if (e[38])
               check({tx_speed, tx_crc_enable, tx_stream}, e[36:32]);
         end
      end

   always @(posedge clock)
      if (!reset && format_error === 1'b1)
         n_err++;

   initial
   begin
      logic [31:0] pk[$];
      logic [1:0] spd;
      int len;
      repeat (12) @(posedge clock);
      check({tx_valid, in_ready, busy, format_error, tx_first, tx_last, tx_crc_enable, tx_speed},
         9'h004);
      node_id <= 16'($random(seed));
      reset <= 1'b0;
      @(posedge clock);
      // Control quadlet waits while the bus is outside its asynchronous phase
      u_atx_host_model.packet(4'h4, 2'b10, 16'h0000, 1'b0, $random(seed), pk);
      expect_pkt(4'h4, 2'b10, 0, pk);
      repeat (30) @(posedge clock);
      check({busy, beats[0]}, 2'b00);
      hold_off <= 1'b0;
      for (int i = 0; i < 48; i++)
      begin
         slow <= i >= 24;
         spd = (i % 12 == 7) ? 2'b11 : 2'($random(seed));
         len = (i < 12) ? 0 : lens[{$random(seed)} % 8];
         exp_err += (tcs[i % 12] == 4'h3 || spd == 2'b11);
         u_atx_host_model.packet(tcs[i % 12], spd, 16'(len), i[0], $random(seed), pk);
         expect_pkt(tcs[i % 12], spd, len, pk);
         repeat ({$random(seed)} % 20) @(posedge clock);
      end
      for (int k = 0; k < 20000 && exp_q.size() != 0; k++)
         @(posedge clock);
      repeat (20) @(posedge clock);
      check(exp_q.size(), 0);
      check(n_err, exp_err);
      complete_run();
   end

   initial
   begin
      repeat (40000) @(posedge clock);
      failures++;
      complete_run();
   end
endmodule : async_transmit_packet_formatter_tb_top
`default_nettype wire
